// file: logic/asou_core.v
// Overview of operation
// RL1 - subtract with borrow: accumulator minus operand minus carry, into accumulator
// RL2 - and group: operand AND accumulator, result into accumulator
// RL3 - or group: operand OR accumulator, result into accumulator
// RL4 - five operand sources: register, immediate, pointer pair, two indexed
// RL5 - subtract decode: register 10011rrr, immediate DE, pointer pair 9E
// RL6 - and decode: register 10100rrr, immediate E6, memory A6
// RL7 - or decode: register 10110rrr, immediate F6, memory B6
// RL8 - indexed: prefix DD or FD, memory opcode, then displacement byte
// RL9 - register field B..L 000..101, accumulator 111, 110 not a register
// RL10 - register forms take one machine cycle of 4 states
// RL11 - immediate and pointer forms take 4 then 3 states
// RL12 - indexed forms take five cycles: 4, 4, 3, 5, 3 states
// RL13 - sign follows bit 7, zero set on zero result
// RL14 - subtract sets half carry on borrow from bit 4
// RL15 - subtract sets subtract flag, carry on full borrow
// RL16 - and sets half carry, clears subtract and carry
// RL17 - or clears half carry, subtract, carry; overflow flag from overflow
// RL18 - displacement is signed and added to the index register
// RL19 - subtract overflow flag is signed two's complement overflow
// RL20 - memory operand read follows opcode, displacement and address cycles
`timescale 1ns/1ps
`include "asou_defs.vh"

module asou_core
#(
    parameter AW = 8
)
(
    // clock and reset
    input  wire          aclk,
    input  wire          aresetn,
    // axi4-lite slave
    input  wire [AW-1:0] s_awaddr,
    input  wire          s_awvalid,
    output wire          s_awready,
    input  wire [31:0]   s_wdata,
    input  wire [3:0]    s_wstrb,
    input  wire          s_wvalid,
    output wire          s_wready,
    output wire [1:0]    s_bresp,
    output wire          s_bvalid,
    input  wire          s_bready,
    input  wire [AW-1:0] s_araddr,
    input  wire          s_arvalid,
    output wire          s_arready,
    output wire [31:0]   s_rdata,
    output wire [1:0]    s_rresp,
    output wire          s_rvalid,
    input  wire          s_rready,
    // processor memory bus
    output reg  [15:0]   mem_addr,
    output reg           mem_rd,
    input  wire [7:0]    mem_rdata
);

    // ********
    // states
    // ********
    localparam ST_IDLE  = 3'h0;
    localparam ST_FETCH = 3'h1;
    localparam ST_IMM   = 3'h2;
    localparam ST_DISP  = 3'h3;
    localparam ST_CALC  = 3'h4;
    localparam ST_OPND  = 3'h5;

    reg [2:0]  state_r;
    reg [2:0]  t_r;
    reg        pref_r;
    reg        idx2_r;
    reg [1:0]  grp_r;
    reg [7:0]  disp_r;
    reg [15:0] pc_r;
    reg [7:0]  a_r;
    reg [7:0]  f_r;
    reg [7:0]  b_r;
    reg [7:0]  c_r;
    reg [7:0]  d_r;
    reg [7:0]  e_r;
    reg [7:0]  h_r;
    reg [7:0]  l_r;
    reg [15:0] idx1_r;
    reg [15:0] idx2_reg_r;
    reg        done_r;
    reg        err_r;

    wire          wr_en;
    wire [AW-1:0] wr_addr;
    wire [31:0]   wr_data;
    wire [3:0]    wr_strb;
    wire [AW-1:0] rd_addr;
    reg  [31:0]   rd_data;
    reg           rd_hit;
    reg           wr_hit;
    reg  [31:0]   wr_old;
    reg  [31:0]   wr_merged;
    wire [7:0]    alu_res;
    wire [7:0]    alu_flags;

    // ********
    // register bus
    // ********
    asou_axil #(
        .AW (AW)
    ) u_axil (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .s_awaddr  (s_awaddr),
        .s_awvalid (s_awvalid),
        .s_awready (s_awready),
        .s_wdata   (s_wdata),
        .s_wstrb   (s_wstrb),
        .s_wvalid  (s_wvalid),
        .s_wready  (s_wready),
        .s_bresp   (s_bresp),
        .s_bvalid  (s_bvalid),
        .s_bready  (s_bready),
        .s_araddr  (s_araddr),
        .s_arvalid (s_arvalid),
        .s_arready (s_arready),
        .s_rdata   (s_rdata),
        .s_rresp   (s_rresp),
        .s_rvalid  (s_rvalid),
        .s_rready  (s_rready),
        .wr_en     (wr_en),
        .wr_addr   (wr_addr),
        .wr_data   (wr_data),
        .wr_strb   (wr_strb),
        .wr_hit    (wr_hit),
        .rd_addr   (rd_addr),
        .rd_data   (rd_data),
        .rd_hit    (rd_hit)
    );

    wire busy = (state_r != ST_IDLE);

    function [31:0] reg_view;
        input [AW-1:0] adr;
        begin
            case (adr)
                `ASOU_ADDR_CTRL:   reg_view = 32'h00000000;
                `ASOU_ADDR_STATUS: reg_view = {29'h0, err_r, done_r, busy};
                `ASOU_ADDR_PC:     reg_view = {16'h0000, pc_r};
                `ASOU_ADDR_AF:     reg_view = {16'h0000, f_r, a_r};
                `ASOU_ADDR_BC:     reg_view = {16'h0000, b_r, c_r};
                `ASOU_ADDR_DE:     reg_view = {16'h0000, d_r, e_r};
                `ASOU_ADDR_PTR:    reg_view = {16'h0000, h_r, l_r};
                `ASOU_ADDR_IDX1:   reg_view = {16'h0000, idx1_r};
                default:           reg_view = {16'h0000, idx2_reg_r};
            endcase
        end
    endfunction

    function map_hit;
        input [AW-1:0] adr;
        begin
            map_hit = (adr[1:0] == 2'h0) && (adr <= `ASOU_ADDR_IDX2);
        end
    endfunction

    always @*
    begin
        rd_hit    = map_hit(rd_addr);
        rd_data   = reg_view(rd_addr);
        wr_hit    = map_hit(wr_addr);
        wr_old    = reg_view(wr_addr);
        wr_merged = {wr_strb[3] ? wr_data[31:24] : wr_old[31:24],
                     wr_strb[2] ? wr_data[23:16] : wr_old[23:16],
                     wr_strb[1] ? wr_data[15:8]  : wr_old[15:8],
                     wr_strb[0] ? wr_data[7:0]   : wr_old[7:0]};
    end

    wire start = wr_en && (wr_addr == `ASOU_ADDR_CTRL) && wr_strb[0] &&
                 wr_data[`ASOU_CTRL_START] && !busy;

    // ********
    // decode of the fetched byte
    // ********
    wire [4:0] top5 = mem_rdata[7:3];
    wire [2:0] low3 = mem_rdata[2:0];
    reg        dec_grp_ok;
    reg  [1:0] dec_grp;
    reg        dec_reg;
    reg        dec_imm;
    reg        dec_mem;

    always @*
    begin
        dec_grp_ok = 1'b1;
        dec_grp    = `ASOU_ALU_SWB;
        // RL5 - subtract decode
        // RL6 - and decode
        // RL7 - or decode
        case (top5)
            `ASOU_TOP_SWB: dec_grp = `ASOU_ALU_SWB;
            `ASOU_TOP_AND: dec_grp = `ASOU_ALU_AND;
            `ASOU_TOP_OR:  dec_grp = `ASOU_ALU_OR;
            default:       dec_grp_ok = 1'b0;
        endcase
        dec_imm = 1'b0;
        case (mem_rdata)
            `ASOU_OP_SWB_IMM:
            begin
                dec_imm = 1'b1;
                dec_grp = `ASOU_ALU_SWB;
            end
            `ASOU_OP_AND_IMM:
            begin
                dec_imm = 1'b1;
                dec_grp = `ASOU_ALU_AND;
            end
            `ASOU_OP_OR_IMM:
            begin
                dec_imm = 1'b1;
                dec_grp = `ASOU_ALU_OR;
            end
            default:
                dec_imm = 1'b0;
        endcase
        // RL9 - code 110 selects memory, not a register
        dec_reg = dec_grp_ok && (low3 != `ASOU_RCODE_MEM);
        dec_mem = dec_grp_ok && (low3 == `ASOU_RCODE_MEM);
    end

    // RL9 - register field select
    function [7:0] reg_pick;
        input [2:0] code;
        begin
            case (code)
                `ASOU_RCODE_B: reg_pick = b_r;
                `ASOU_RCODE_C: reg_pick = c_r;
                `ASOU_RCODE_D: reg_pick = d_r;
                `ASOU_RCODE_E: reg_pick = e_r;
                `ASOU_RCODE_H: reg_pick = h_r;
                `ASOU_RCODE_L: reg_pick = l_r;
                default:       reg_pick = a_r;
            endcase
        end
    endfunction

    // ********
    // execute
    // ********
    wire fetch_end = (state_r == ST_FETCH) && (t_r == `ASOU_T_FETCH - 3'h1);
    wire read_end  = (t_r == `ASOU_T_READ - 3'h1);
    // RL10 - register form ends with its opcode fetch
    wire exec_reg  = fetch_end && !pref_r && dec_reg;
    // RL20 - memory operand taken at the end of its read cycle
    wire exec_mem  = read_end &&
                     ((state_r == ST_IMM) || (state_r == ST_OPND));
    wire exec_en   = exec_reg || exec_mem;
    wire [1:0] exec_grp  = exec_reg ? dec_grp : grp_r;
    // RL4 - operand source select
    wire [7:0] exec_opnd = exec_reg ? reg_pick(low3) : mem_rdata;

    asou_alu u_alu (
        .op    (exec_grp),
        .acc   (a_r),
        .opnd  (exec_opnd),
        .cin   (f_r[`ASOU_FLAG_C]),
        .res   (alu_res),
        .flags (alu_flags)
    );

    // RL18 - signed displacement added to the chosen index register
    wire [15:0] idx_base = idx2_r ? idx2_reg_r : idx1_r;
    wire [15:0] eff_addr = idx_base + {{8{disp_r[7]}}, disp_r};
    wire [15:0] pc_inc   = pc_r + 16'h0001;

    // ********
    // sequencer and register file
    // ********
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_r    <= ST_IDLE;
            t_r        <= 3'h0;
            pref_r     <= 1'b0;
            idx2_r     <= 1'b0;
            grp_r      <= `ASOU_ALU_SWB;
            disp_r     <= `ASOU_RST_BYTE;
            pc_r       <= `ASOU_RST_WORD;
            a_r        <= `ASOU_RST_BYTE;
            f_r        <= `ASOU_RST_BYTE;
            b_r        <= `ASOU_RST_BYTE;
            c_r        <= `ASOU_RST_BYTE;
            d_r        <= `ASOU_RST_BYTE;
            e_r        <= `ASOU_RST_BYTE;
            h_r        <= `ASOU_RST_BYTE;
            l_r        <= `ASOU_RST_BYTE;
            idx1_r     <= `ASOU_RST_WORD;
            idx2_reg_r <= `ASOU_RST_WORD;
            done_r     <= 1'b0;
            err_r      <= 1'b0;
            mem_addr   <= `ASOU_RST_WORD;
            mem_rd     <= 1'b0;
        end
        else
        begin
            // software writes first; the datapath below overrides them
            if (wr_en && !busy)
            begin
                case (wr_addr)
                    `ASOU_ADDR_PC:   pc_r <= wr_merged[15:0];
                    `ASOU_ADDR_AF:   {f_r, a_r} <= wr_merged[15:0];
                    `ASOU_ADDR_BC:   {b_r, c_r} <= wr_merged[15:0];
                    `ASOU_ADDR_DE:   {d_r, e_r} <= wr_merged[15:0];
                    `ASOU_ADDR_PTR:  {h_r, l_r} <= wr_merged[15:0];
                    `ASOU_ADDR_IDX1: idx1_r <= wr_merged[15:0];
                    `ASOU_ADDR_IDX2: idx2_reg_r <= wr_merged[15:0];
                    default:         pc_r <= pc_r;
                endcase
            end
            t_r <= t_r + 3'h1;
            case (state_r)
                ST_IDLE:
                begin
                    t_r <= 3'h0;
                    if (start)
                    begin
                        state_r  <= ST_FETCH;
                        pref_r   <= 1'b0;
                        done_r   <= 1'b0;
                        err_r    <= 1'b0;
                        mem_addr <= pc_r;
                        mem_rd   <= 1'b1;
                    end
                end
                ST_FETCH:
                begin
                    if (fetch_end)
                    begin
                        t_r      <= 3'h0;
                        pc_r     <= pc_inc;
                        mem_addr <= pc_inc;
                        grp_r    <= dec_grp;
                        // RL8 - prefix selects index register
                        if (!pref_r && (mem_rdata == `ASOU_PFX_IDX1 ||
                                        mem_rdata == `ASOU_PFX_IDX2))
                        begin
                            pref_r <= 1'b1;
                            idx2_r <= (mem_rdata == `ASOU_PFX_IDX2);
                        end
                        // RL12 - indexed: displacement read next
                        else if (pref_r && dec_mem)
                            state_r <= ST_DISP;
                        // RL11 - immediate byte read next
                        else if (!pref_r && dec_imm)
                            state_r <= ST_IMM;
                        // RL11 - pointer pair read next
                        else if (!pref_r && dec_mem)
                        begin
                            state_r  <= ST_OPND;
                            mem_addr <= {h_r, l_r};
                        end
                        else
                        begin
                            // register form finishes here; others invalid
                            state_r <= ST_IDLE;
                            mem_rd  <= 1'b0;
                            done_r  <= 1'b1;
                            err_r   <= !exec_reg;
                        end
                    end
                end
                ST_IMM:
                begin
                    if (read_end)
                        pc_r <= pc_inc;
                end
                ST_DISP:
                begin
                    if (read_end)
                    begin
                        t_r     <= 3'h0;
                        pc_r    <= pc_inc;
                        disp_r  <= mem_rdata;
                        mem_rd  <= 1'b0;
                        state_r <= ST_CALC;
                    end
                end
                ST_CALC:
                begin
                    // RL12 - five-state address cycle
                    if (t_r == `ASOU_T_CALC - 3'h1)
                    begin
                        t_r      <= 3'h0;
                        mem_addr <= eff_addr;
                        mem_rd   <= 1'b1;
                        state_r  <= ST_OPND;
                    end
                end
                ST_OPND:
                    t_r <= t_r;
                default:
                    state_r <= ST_IDLE;
            endcase
            if (state_r == ST_OPND)
                t_r <= t_r + 3'h1;
            if (exec_mem)
            begin
                t_r     <= 3'h0;
                mem_rd  <= 1'b0;
                done_r  <= 1'b1;
                state_r <= ST_IDLE;
            end
            if (exec_en)
            begin
                // RL1 - result written back with flags
                a_r <= alu_res;
                f_r <= alu_flags;
            end
        end
    end

endmodule

// file: logic/asou_defs.vh
`ifndef ASOU_DEFS_VH
`define ASOU_DEFS_VH

// ********
// register byte offsets
// ********
`define ASOU_ADDR_CTRL      8'h00
`define ASOU_ADDR_STATUS    8'h04
`define ASOU_ADDR_PC        8'h08
`define ASOU_ADDR_AF        8'h0C
`define ASOU_ADDR_BC        8'h10
`define ASOU_ADDR_DE        8'h14
`define ASOU_ADDR_PTR       8'h18
`define ASOU_ADDR_IDX1      8'h1C
`define ASOU_ADDR_IDX2      8'h20

// ********
// register fields and reset values
// ********
`define ASOU_CTRL_START     0
`define ASOU_RST_BYTE       8'h00
`define ASOU_RST_WORD       16'h0000

// ********
// flag bit positions
// ********
`define ASOU_FLAG_S         7
`define ASOU_FLAG_Z         6
`define ASOU_FLAG_H         4
`define ASOU_FLAG_PV        2
`define ASOU_FLAG_N         1
`define ASOU_FLAG_C         0

// ********
// opcodes
// ********
`define ASOU_TOP_SWB        5'h13
`define ASOU_TOP_AND        5'h14
`define ASOU_TOP_OR         5'h16
`define ASOU_OP_SWB_IMM     8'hDE
`define ASOU_OP_SWB_MEM     8'h9E
`define ASOU_OP_AND_IMM     8'hE6
`define ASOU_OP_AND_MEM     8'hA6
`define ASOU_OP_OR_IMM      8'hF6
`define ASOU_OP_OR_MEM      8'hB6
`define ASOU_PFX_IDX1       8'hDD
`define ASOU_PFX_IDX2       8'hFD
`define ASOU_RCODE_B        3'h0
`define ASOU_RCODE_C        3'h1
`define ASOU_RCODE_D        3'h2
`define ASOU_RCODE_E        3'h3
`define ASOU_RCODE_H        3'h4
`define ASOU_RCODE_L        3'h5
`define ASOU_RCODE_MEM      3'h6
`define ASOU_RCODE_A        3'h7

// ********
// alu operations and clock states per machine cycle
// ********
`define ASOU_ALU_SWB        2'h0
`define ASOU_ALU_AND        2'h1
`define ASOU_ALU_OR         2'h2
`define ASOU_T_FETCH        3'h4
`define ASOU_T_READ         3'h3
`define ASOU_T_CALC         3'h5

`endif

// file: logic/asou_alu.v
`timescale 1ns/1ps
`include "asou_defs.vh"

module asou_alu
(
    // operation
    input  wire [1:0] op,
    input  wire [7:0] acc,
    input  wire [7:0] opnd,
    input  wire       cin,
    // result
    output reg  [7:0] res,
    output reg  [7:0] flags
);

    reg [8:0] diff;
    reg [4:0] hdiff;

    always @*
    begin
        diff  = {1'b0, acc} - {1'b0, opnd} - {8'h00, cin};
        hdiff = {1'b0, acc[3:0]} - {1'b0, opnd[3:0]} - {4'h0, cin};
        flags = 8'h00;
        case (op)
            // RL1 - subtract with borrow
            `ASOU_ALU_SWB:
            begin
                res = diff[7:0];
                // RL14 - borrow from bit 4
                flags[`ASOU_FLAG_H] = hdiff[4];
                // RL15 - subtract and carry
                flags[`ASOU_FLAG_N] = 1'b1;
                flags[`ASOU_FLAG_C] = diff[8];
                // RL19 - signed overflow
                flags[`ASOU_FLAG_PV] = (acc[7] != opnd[7]) &&
                                       (diff[7] != acc[7]);
            end
            // RL2 - bitwise and
            `ASOU_ALU_AND:
            begin
                res = acc & opnd;
                // RL16 - half carry set
                flags[`ASOU_FLAG_H] = 1'b1;
            end
            // RL3 - bitwise or
            default:
            begin
                // RL17 - logical op cannot overflow, flags cleared
                res = acc | opnd;
            end
        endcase
        // RL13 - sign and zero
        flags[`ASOU_FLAG_S] = res[7];
        flags[`ASOU_FLAG_Z] = (res == 8'h00);
    end

endmodule

// file: logic/asou_axil.v
`timescale 1ns/1ps

module asou_axil
#(
    parameter AW = 8
)
(
    // clock and reset
    input  wire          aclk,
    input  wire          aresetn,
    // write address and data
    input  wire [AW-1:0] s_awaddr,
    input  wire          s_awvalid,
    output wire          s_awready,
    input  wire [31:0]   s_wdata,
    input  wire [3:0]    s_wstrb,
    input  wire          s_wvalid,
    output wire          s_wready,
    // write response
    output reg  [1:0]    s_bresp,
    output reg           s_bvalid,
    input  wire          s_bready,
    // read address and data
    input  wire [AW-1:0] s_araddr,
    input  wire          s_arvalid,
    output wire          s_arready,
    output reg  [31:0]   s_rdata,
    output reg  [1:0]    s_rresp,
    output reg           s_rvalid,
    input  wire          s_rready,
    // register file side
    output wire          wr_en,
    output wire [AW-1:0] wr_addr,
    output wire [31:0]   wr_data,
    output wire [3:0]    wr_strb,
    input  wire          wr_hit,
    output wire [AW-1:0] rd_addr,
    input  wire [31:0]   rd_data,
    input  wire          rd_hit
);

    reg          aw_full_r;
    reg [AW-1:0] aw_addr_r;
    reg          w_full_r;
    reg [31:0]   w_data_r;
    reg [3:0]    w_strb_r;

    // address and data may arrive in either order; hold each until both
    assign s_awready = !aw_full_r && !s_bvalid;
    assign s_wready  = !w_full_r && !s_bvalid;
    assign wr_en     = aw_full_r && w_full_r && !s_bvalid;
    assign wr_addr   = aw_addr_r;
    assign wr_data   = w_data_r;
    assign wr_strb   = w_strb_r;
    assign s_arready = !s_rvalid;
    assign rd_addr   = s_araddr;

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_full_r <= 1'b0;
            aw_addr_r <= {AW{1'b0}};
            w_full_r  <= 1'b0;
            w_data_r  <= 32'h00000000;
            w_strb_r  <= 4'h0;
            s_bvalid  <= 1'b0;
            s_bresp   <= 2'h0;
            s_rvalid  <= 1'b0;
            s_rdata   <= 32'h00000000;
            s_rresp   <= 2'h0;
        end
        else
        begin
            if (s_awvalid && s_awready)
            begin
                aw_full_r <= 1'b1;
                aw_addr_r <= s_awaddr;
            end
            if (s_wvalid && s_wready)
            begin
                w_full_r <= 1'b1;
                w_data_r <= s_wdata;
                w_strb_r <= s_wstrb;
            end
            if (wr_en)
            begin
                aw_full_r <= 1'b0;
                w_full_r  <= 1'b0;
                s_bvalid  <= 1'b1;
                s_bresp   <= wr_hit ? 2'h0 : 2'h2;
            end
            else if (s_bvalid && s_bready)
                s_bvalid <= 1'b0;
            if (s_arvalid && s_arready)
            begin
                s_rvalid <= 1'b1;
                s_rdata  <= rd_hit ? rd_data : 32'h00000000;
                s_rresp  <= rd_hit ? 2'h0 : 2'h2;
            end
            else if (s_rvalid && s_rready)
                s_rvalid <= 1'b0;
        end
    end

endmodule

// file: sim/asou_core_asserts.sv
`timescale 1ns/1ps
module asou_chk
(
    // clock and reset
    input logic        aclk,
    input logic        aresetn,
    // register bus
    input logic        s_awvalid,
    input logic        s_awready,
    input logic        s_bvalid,
    input logic [1:0]  s_bresp,
    input logic        s_bready,
    input logic        s_arvalid,
    input logic        s_arready,
    input logic        s_rvalid,
    input logic [31:0] s_rdata,
    input logic        s_rready,
    // memory bus
    input logic [15:0] mem_addr,
    input logic        mem_rd
);
    default clocking dc @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ****************
    // properties
    // ****************
    property p_bv; s_awvalid && s_awready |-> ##[1:3] s_bvalid; endproperty
    a_bv: assert property (p_bv) else $error("no write answer");
    property p_bh; s_bvalid && !s_bready |=> s_bvalid && $stable(s_bresp);
    endproperty
    a_bh: assert property (p_bh) else $error("write answer lost");
    property p_rv; s_arvalid && s_arready |=> s_rvalid; endproperty
    a_rv: assert property (p_rv) else $error("no read answer");
    property p_rh; s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata);
    endproperty
    a_rh: assert property (p_rh) else $error("read data moved");
    property p_ms; $rose(mem_rd) |-> mem_rd [*3]; endproperty
    a_ms: assert property (p_ms) else $error("cycle too short");
    property p_mc; $rose(mem_rd) |=> $stable(mem_addr) [*2]; endproperty
    a_mc: assert property (p_mc) else $error("address moved");
    // the indexed address cycle is the only gap inside an instruction
    property p_gap; $fell(mem_rd) |-> !mem_rd [*5]; endproperty
    a_gap: assert property (p_gap) else $error("gap too short");
    property p_rst; $rose(aresetn) |-> !s_bvalid && !s_rvalid && !mem_rd;
    endproperty
    a_rst: assert property (p_rst) else $error("busy after reset");
    cover property ($rose(mem_rd));
    cover property (s_rvalid && !s_rready);
    cover property (s_bvalid && s_bresp == 2'h2);
endmodule

bind asou_core asou_chk i_chk (.*);

// file: sim/asou_mem_model.sv
`timescale 1ns/1ps
module asou_mem_model
(
    // processor bus
    input  logic        aclk,
    input  logic [15:0] mem_addr,
    input  logic        mem_rd,
    output logic [7:0]  mem_rdata
);
    logic [7:0] m [0:65535];
    logic [7:0] last_r = 8'h00;
    // plain read
    // idle bus shows the inverted last byte so stale data never matches
    assign mem_rdata = mem_rd ? m[mem_addr] : ~last_r;
    always @(posedge aclk)
        if (mem_rd)
            last_r <= m[mem_addr];
endmodule

// file: sim/asou_bench.sv
`timescale 1ns/1ps
`include "asou_defs.vh"
module asou_bench;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [7:0]  s_awaddr = 8'h00;
    logic [7:0]  s_araddr = 8'h00;
    logic [31:0] s_wdata = 32'h0;
    logic        s_awvalid = 1'b0;
    logic        s_wvalid = 1'b0;
    logic        s_bready = 1'b0;
    logic        s_arvalid = 1'b0;
    logic        s_rready = 1'b0;
    wire         s_awready, s_wready, s_bvalid, s_arready, s_rvalid, mem_rd;
    wire [1:0]   s_bresp, s_rresp;
    wire [31:0]  s_rdata;
    wire [15:0]  mem_addr;
    wire [7:0]   mem_rdata;
    logic [31:0] rv;
    logic [1:0]  rr;
    int          err_count = 0;
    int          check_count = 0;
    int          n_rd = 0;
    time         t0, t1;
    // opcode bytes, a in, f in, operand, a out, f out
    logic [63:0] rows [0:18] = '{
        64'h9800001601051002, 64'hDE0100000001FF93, 64'h9E00008000017F16,
        64'hDD9EFF0501040042, 64'hFD9EFF3C013CFF93, 64'h9F00001000000042,
        64'hA00000C3007B4310, 64'hA20000F0010F0050, 64'hE68000FF00808090,
        64'hFDA6FF0F03FF0F10, 64'hB500001213001200, 64'hB400001200003200,
        64'hB100004800125A00, 64'hB700000003000040, 64'hF680000100808180,
        64'hB600000000000040, 64'hDDB6FF0F00F0FF80, 64'hA600000F00F00050,
        64'h9B00000000808087};
    asou_core i_asou_core (.aclk(aclk), .aresetn(aresetn),
        .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready),
        .s_wdata(s_wdata), .s_wstrb(4'hF), .s_wvalid(s_wvalid),
        .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid),
        .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
        .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp),
        .s_rvalid(s_rvalid), .s_rready(s_rready), .mem_addr(mem_addr),
        .mem_rd(mem_rd), .mem_rdata(mem_rdata));
    asou_mem_model mem (.*);
    initial
        forever #10 aclk = ~aclk;
    // span of bus activity stands in for the instruction's clock states
    always @(posedge aclk)
        if (mem_rd === 1'b1)
        begin
            if (n_rd == 0)
                t0 = $time;
            t1 = $time;
            n_rd++;
        end
    task results;
        if (err_count == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e)
        begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        s_awaddr <= a;
        s_wdata <= d;
        s_awvalid <= 1'b1;
        s_wvalid <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_awready) s_awvalid <= 1'b0;
            if (s_wready) s_wvalid <= 1'b0;
        end while ((s_awvalid && !s_awready) || (s_wvalid && !s_wready));
        s_bready <= 1'b1;
        do @(posedge aclk); while (s_bvalid !== 1'b1);
        rr = s_bresp;
        s_bready <= 1'b0;
    endtask
    task rd(input logic [7:0] a);
        s_araddr <= a;
        s_arvalid <= 1'b1;
        do @(posedge aclk); while (s_arready !== 1'b1);
        s_arvalid <= 1'b0;
        do @(posedge aclk); while (s_rvalid !== 1'b1);
        s_rready <= 1'b1;
        @(posedge aclk);
        rv = s_rdata;
        rr = s_rresp;
        s_rready <= 1'b0;
    endtask
    task run(input logic [63:0] r, input logic [31:0] st);
        logic ix;
        ix = r[63:56] == 8'hDD || r[63:56] == 8'hFD;
        mem.m[16'h0100] = r[63:56];
        mem.m[16'h0101] = r[55:48];
        mem.m[16'h0102] = r[47:40];
        mem.m[16'h2000] = r[23:16];
        mem.m[16'h2FFF] = r[23:16];
        wr(`ASOU_ADDR_PC, 32'h100);
        wr(`ASOU_ADDR_AF, {16'h0, r[31:24], r[39:32]});
        wr(`ASOU_ADDR_BC, {16'h0, r[23:16], r[23:16]});
        wr(`ASOU_ADDR_DE, {16'h0, r[23:16], r[23:16]});
        n_rd = 0;
        wr(`ASOU_ADDR_CTRL, 32'h1);
        rv = 32'h0;
        while (rv[1] !== 1'b1) rd(`ASOU_ADDR_STATUS);
        chk("status", st, rv);
        rd(`ASOU_ADDR_AF);
        chk("acc_flags", {16'h0, r[7:0], r[15:8]}, rv);
        if (st == 32'h2)
        begin
            chk("states", ix ? 19 : r[58:56] == 3'h6 ? 7 : 4,
                32'((t1 - t0) / 20 + 1));
            rd(`ASOU_ADDR_PC);
            chk("pc", 32'h100 + (ix ? 3 : r[58:56] == 3'h6 && r[62] ? 2 : 1),
                rv);
        end
    endtask
    initial
    begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        wr(`ASOU_ADDR_PTR, 32'h2000);
        wr(`ASOU_ADDR_IDX1, 32'h3000);
        wr(`ASOU_ADDR_IDX2, 32'h3000);
        for (int i = 0; i < 19; i++)
            run(rows[i], 32'h2);
        run(64'hDD98005500005500, 32'h6);
        rd(8'h40);
        chk("unmapped_rd", 32'h2, {30'h0, rr});
        wr(8'h40, 32'h1);
        chk("unmapped_wr", 32'h2, {30'h0, rr});
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(`ASOU_ADDR_AF);
        chk("af_reset", 32'h0, rv);
        results;
    end
    initial
    begin
        #400000;
        err_count++;
        results;
    end
endmodule
